// ===== core/gdic_top.sv
`timescale 1ns/1ps
module gdic_top
   import gdic_pkg::*;
#(
   parameter int NPH = NUM_PHASES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Phase command pins
   input wire logic [NPH-1:0] high_side_cmd_n,
   input wire logic [NPH-1:0] low_side_cmd,
   // Shutdown pins
   input wire logic bridge_enable,
   input wire logic inhibit_sleep_n,
   input wire logic safe_off,
   // Analog comparators
   input wire logic [NPH-1:0] phase_node_above,
   input wire logic vio_uv_det,
   input wire logic vio_ov_det,
   input wire logic bootstrap_supply_uv,
   input wire logic io_supply_ok,
   // Pad short detectors: feedback 0..2, fault, serial out
   input wire logic [NUM_DOUT-1:0] dout_short,
   // Serial data pad
   input wire logic chip_select_n,
   input wire logic sdo_data,
   output logic sdo_out,
   output logic sdo_oe_n,
   output logic shift_start,
   output logic frame_end,
   // Gate drive
   output logic [NPH-1:0] gate_hs_on,
   output logic [NPH-1:0] gate_ls_on,
   // Feedback and fault pins
   output logic [NPH-1:0] phase_feedback,
   output logic [NPH-1:0] phase_feedback_oe_n,
   output logic fault_n,
   output logic fault_oe_n,
   // Power and monitor control
   output logic supplies_en,
   output logic sleep_mode,
   output logic vio_thr_3v3,
   output logic vio_mon_active,
   // Interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_s1_ff;
   logic rst_s2_ff;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   assign rst_n = rst_s2_ff;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_ff;
   logic [PIN_W-1:0] pin_ff;

   assign pin_raw = {chip_select_n, io_supply_ok, dout_short, bootstrap_supply_uv, vio_ov_det,
                     vio_uv_det, phase_node_above, safe_off, inhibit_sleep_n, bridge_enable,
                     low_side_cmd, high_side_cmd_n};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= PIN_RST;
         pin_ff <= PIN_RST;
      end else begin
         pin_s1_ff <= pin_raw;
         pin_ff <= pin_s1_ff;
      end
   end

   logic [NPH-1:0] hs_n_s;
   logic [NPH-1:0] ls_s;
   logic en_s;
   logic inh_n_s;
   logic safe_off_s;
   logic [NPH-1:0] pn_s;
   logic vuv_s;
   logic vov_s;
   logic buv_s;
   logic [NUM_DOUT-1:0] short_s;
   logic vok_s;
   logic cs_n_s;

   assign hs_n_s = pin_ff[2:0];
   assign ls_s = pin_ff[5:3];
   assign en_s = pin_ff[6];
   assign inh_n_s = pin_ff[7];
   assign safe_off_s = pin_ff[8];
   assign pn_s = pin_ff[11:9];
   assign vuv_s = pin_ff[12];
   assign vov_s = pin_ff[13];
   assign buv_s = pin_ff[14];
   assign short_s = pin_ff[19:15];
   assign vok_s = pin_ff[20];
   assign cs_n_s = pin_ff[21];

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   logic wr_ctrl;
   logic wr_irq_stat;
   logic wr_irq_mask;
   logic rd_err;

   assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
   assign wr_irq_stat = reg_wr && (reg_addr == IRQ_STAT_OFS);
   assign wr_irq_mask = reg_wr && (reg_addr == IRQ_MASK_OFS);
   assign rd_err = reg_rd && (reg_addr == ERR_OFS);

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   gdic_pwr_t pwr_ff;
   gdic_pwr_t nxt_pwr;

   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         ST_ACTIVE: begin
            if (!inh_n_s) begin
               nxt_pwr = ST_PWRDN;
            end
         end
         ST_PWRDN: begin
            if (inh_n_s) begin
               nxt_pwr = ST_ACTIVE;
            end else if (buv_s) begin
               nxt_pwr = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (inh_n_s) begin
               nxt_pwr = ST_ACTIVE;
            end
         end
         default: begin
            nxt_pwr = ST_PWRDN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_ff <= ST_PWRDN;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   logic powered;
   assign powered = (pwr_ff == ST_ACTIVE);

   // ----------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------
   logic [DEAD_W-1:0] dead_ff;
   logic vsel_ff;
   logic vmon_ff;
   logic cfg_ff;
   logic cfg_lost;

   assign cfg_lost = !inh_n_s || !powered;

   // writes change thresholds and monitor enable only in configuration mode; losing power restores their reset values
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dead_ff <= CTRL_DEAD_RST;
         vsel_ff <= CTRL_VSEL_RST;
         vmon_ff <= CTRL_VMON_RST;
         cfg_ff <= CTRL_CFG_RST;
      end else if (cfg_lost) begin
         dead_ff <= CTRL_DEAD_RST;
         vsel_ff <= CTRL_VSEL_RST;
         vmon_ff <= CTRL_VMON_RST;
         cfg_ff <= CTRL_CFG_RST;
      end else if (wr_ctrl) begin
         dead_ff <= reg_wdata[CTRL_DEAD_LSB +: DEAD_W];
         cfg_ff <= reg_wdata[CTRL_CFG_BIT];
         if (cfg_ff) begin
            vsel_ff <= reg_wdata[CTRL_VSEL_BIT];
            vmon_ff <= reg_wdata[CTRL_VMON_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Error register
   // ----------------------------------------------------------------
   logic [ERR_W-1:0] err_ff;
   logic [ERR_W-1:0] err_set;
   logic [ERR_W-1:0] nxt_err;

   assign err_set = {short_s,
                     buv_s && powered,
                     vov_s && vmon_ff && powered,
                     vuv_s && vmon_ff && powered};

   // read clears, a new event in the same cycle survives
   assign nxt_err = (err_ff & ~(rd_err ? {ERR_W{1'b1}} : {ERR_W{1'b0}})) | err_set;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_ff <= ERR_RST;
      end else begin
         err_ff <= nxt_err;
      end
   end

   // ----------------------------------------------------------------
   // Fault latch
   // ----------------------------------------------------------------
   logic en_d_ff;
   logic fault_lat_ff;
   logic en_fall;

   assign en_fall = en_d_ff && !en_s;

   // falling enable edge clears the latched fault
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_d_ff <= 1'b0;
         fault_lat_ff <= 1'b0;
      end else begin
         en_d_ff <= en_s;
         if (|err_set) begin
            fault_lat_ff <= 1'b1;
         end else if (en_fall) begin
            fault_lat_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Gate drive
   // ----------------------------------------------------------------
   logic run;
   logic [NPH-1:0] hs_on;
   logic [NPH-1:0] ls_on;
   logic [NPH-1:0] gate_hs_ff;
   logic [NPH-1:0] gate_ls_ff;

   assign run = en_s && powered && !fault_lat_ff;

   genvar ph;
   generate
      for (ph = 0; ph < NPH; ph++) begin : g_phase
         gdic_dead_time u_dead (
            .clk(clk),
            .rst_n(rst_n),
            .dead_cycles(dead_ff),
            .hs_req(run && !hs_n_s[ph]),
            .ls_req(run && ls_s[ph]),
            .hs_on(hs_on[ph]),
            .ls_on(ls_on[ph])
         );
      end
   endgenerate

   // safe-off gates the final stage, bypassing enable and fault logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_hs_ff <= '0;
         gate_ls_ff <= '0;
      end else begin
         gate_hs_ff <= safe_off_s ? '0 : hs_on;
         gate_ls_ff <= safe_off_s ? '0 : ls_on;
      end
   end

   assign gate_hs_on = gate_hs_ff;
   assign gate_ls_on = gate_ls_ff;

   // ----------------------------------------------------------------
   // Feedback and fault pins
   // ----------------------------------------------------------------
   logic [NPH-1:0] pfb_ff;
   logic fault_n_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pfb_ff <= '0;
         fault_n_ff <= 1'b1;
      end else begin
         pfb_ff <= pn_s;
         fault_n_ff <= !(fault_lat_ff || (|err_ff));
      end
   end

   // shorted pads stay released until the error is read
   assign phase_feedback = pfb_ff;
   assign phase_feedback_oe_n = err_ff[ERR_SHORT_LSB +: NPH];
   assign fault_n = fault_n_ff;
   assign fault_oe_n = err_ff[ERR_SHORT_LSB + 3];

   // ----------------------------------------------------------------
   // Serial data pad and framing
   // ----------------------------------------------------------------
   logic cs_d_ff;
   logic sdo_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_d_ff <= 1'b1;
         sdo_ff <= 1'b0;
      end else begin
         cs_d_ff <= cs_n_s;
         sdo_ff <= sdo_data;
      end
   end

   // chip select edges frame a transfer
   assign shift_start = cs_d_ff && !cs_n_s;
   assign frame_end = !cs_d_ff && cs_n_s;

   assign sdo_out = sdo_ff;
   assign sdo_oe_n = !(vok_s && !cs_n_s && !err_ff[ERR_SHORT_LSB + 4]);

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   logic [ERR_W-1:0] irq_stat_ff;
   logic [ERR_W-1:0] irq_mask_ff;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= ERR_RST;
         irq_mask_ff <= IRQ_MASK_RST;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~(wr_irq_stat ? reg_wdata[ERR_W-1:0] : '0)) | err_set;
         if (wr_irq_mask) begin
            irq_mask_ff <= reg_wdata[ERR_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // ----------------------------------------------------------------
   // Read-back
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] rdata_ff;

   always_comb begin
      case (reg_addr)
         CTRL_OFS: rd_mux = {21'h0, cfg_ff, vmon_ff, vsel_ff, dead_ff};
         STAT_OFS: rd_mux = {17'h0, pwr_ff, fault_lat_ff, safe_off_s, inh_n_s, en_s,
                             pfb_ff, gate_ls_ff, gate_hs_ff};
         ERR_OFS: rd_mux = {24'h0, err_ff};
         IRQ_STAT_OFS: rd_mux = {24'h0, irq_stat_ff};
         IRQ_MASK_OFS: rd_mux = {24'h0, irq_mask_ff};
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (reg_rd) begin
         rdata_ff <= rd_mux;
      end else begin
         rdata_ff <= '0;
      end
   end

   assign reg_rdata = rdata_ff;
   assign supplies_en = (pwr_ff != ST_SLEEP);
   assign sleep_mode = (pwr_ff == ST_SLEEP);
   assign vio_thr_3v3 = vsel_ff;
   assign vio_mon_active = vmon_ff;

endmodule

// ===== core/gdic_pkg.sv
package gdic_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_PHASES = 3;
   localparam int NUM_DOUT = 5;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DEAD_W = 8;
   localparam int ERR_W = 8;
   localparam int PIN_W = 22;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] ERR_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h10;

   // ----------------------------------------------------------------
   // Control register fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_DEAD_LSB = 0;
   localparam int CTRL_VSEL_BIT = 8;
   localparam int CTRL_VMON_BIT = 9;
   localparam int CTRL_CFG_BIT = 10;
   localparam logic [DEAD_W-1:0] CTRL_DEAD_RST = 8'h10;
   localparam logic CTRL_VSEL_RST = 1'b0;
   localparam logic CTRL_VMON_RST = 1'b1;
   localparam logic CTRL_CFG_RST = 1'b1;

   // ----------------------------------------------------------------
   // Error / interrupt bit positions (same layout)
   // ----------------------------------------------------------------
   localparam int ERR_VIO_UV = 0;
   localparam int ERR_VIO_OV = 1;
   localparam int ERR_BOOT_UV = 2;
   localparam int ERR_SHORT_LSB = 3;
   localparam logic [ERR_W-1:0] ERR_RST = 8'h00;
   localparam logic [ERR_W-1:0] IRQ_MASK_RST = 8'h00;

   // Synchroniser reset image: idle pin levels (high-side off, chip select off)
   localparam logic [PIN_W-1:0] PIN_RST = 22'h000007 | (22'h1 << 21);

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b00,
      ST_PWRDN = 2'b01,
      ST_SLEEP = 2'b10
   } gdic_pwr_t;

   typedef enum logic [1:0] {
      DRV_OFF = 2'b00,
      DRV_HS = 2'b01,
      DRV_LS = 2'b10
   } gdic_drv_t;

endpackage

// ===== core/gdic_dead_time.sv
`timescale 1ns/1ps
module gdic_dead_time
   import gdic_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic [DEAD_W-1:0] dead_cycles,
   input wire logic hs_req,
   input wire logic ls_req,
   // Drive
   output logic hs_on,
   output logic ls_on
);

   gdic_drv_t drv_ff;
   gdic_drv_t nxt_drv;
   logic [DEAD_W-1:0] cnt_ff;
   logic [DEAD_W-1:0] nxt_cnt;
   gdic_drv_t want;

   // Both requested at once means neither switch may conduct
   function automatic gdic_drv_t want_of(input logic hs, input logic ls);
      if (hs && !ls) begin
         return DRV_HS;
      end else if (ls && !hs) begin
         return DRV_LS;
      end
      return DRV_OFF;
   endfunction

   assign want = want_of(hs_req, ls_req);

   always_comb begin
      nxt_drv = drv_ff;
      nxt_cnt = cnt_ff;
      if (want != drv_ff) begin
         if (drv_ff != DRV_OFF) begin
            nxt_drv = DRV_OFF;
            nxt_cnt = dead_cycles;
         end else if (cnt_ff == '0) begin
            nxt_drv = want;
         end else begin
            nxt_cnt = cnt_ff - 8'h01;
         end
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_ff <= DRV_OFF;
         cnt_ff <= '0;
      end else begin
         drv_ff <= nxt_drv;
         cnt_ff <= nxt_cnt;
      end
   end

   assign hs_on = (drv_ff == DRV_HS);
   assign ls_on = (drv_ff == DRV_LS);

endmodule

// ===== test/gdic_top_asserts.sv
`timescale 1ns/1ps
module gdic_top_asserts
   import gdic_pkg::*;
#(
   parameter int NPH = NUM_PHASES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pins
   input wire logic [NPH-1:0] high_side_cmd_n,
   input wire logic bridge_enable,
   input wire logic inhibit_sleep_n,
   input wire logic safe_off,
   input wire logic [NPH-1:0] phase_node_above,
   input wire logic [NUM_DOUT-1:0] dout_short,
   input wire logic chip_select_n,
   // Outputs
   input wire logic sdo_oe_n,
   input wire logic shift_start,
   input wire logic [NPH-1:0] gate_hs_on,
   input wire logic [NPH-1:0] gate_ls_on,
   input wire logic [NPH-1:0] phase_feedback,
   input wire logic [NPH-1:0] phase_feedback_oe_n,
   input wire logic fault_n,
   input wire logic supplies_en
);
   // Pin synchronisers need a few cycles after reset before any check means anything
   logic [3:0] up_ff;
   logic rdy;
   assign rdy = (up_ff == 4'hf);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         up_ff <= 4'h0;
      end else if (!rdy) begin
         up_ff <= up_ff + 4'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn || !rdy);
   property p_excl; (gate_hs_on & gate_ls_on) == '0; endproperty
   a_excl: assert property (p_excl) else $error("both gates of a bridge on");
   property p_ena_off; (!bridge_enable)[*4] |=> (gate_hs_on | gate_ls_on) == '0; endproperty
   a_ena_off: assert property (p_ena_off) else $error("gate on while disabled");
   property p_safe_off; safe_off[*4] |=> (gate_hs_on | gate_ls_on) == '0; endproperty
   a_safe_off: assert property (p_safe_off) else $error("gate on in safe off");
   property p_hs_idle; high_side_cmd_n[0][*5] |=> !gate_hs_on[0]; endproperty
   a_hs_idle: assert property (p_hs_idle) else $error("high side on while idle");
   property p_dead; $fell(gate_hs_on[0]) |=> (!gate_ls_on[0])[*8]; endproperty
   a_dead: assert property (p_dead) else $error("dead time too short");
   property p_inh; (!inhibit_sleep_n)[*4] |=> (gate_hs_on | gate_ls_on) == '0; endproperty
   a_inh: assert property (p_inh) else $error("gate on during power down");
   property p_fb; (phase_node_above[0] && supplies_en)[*4] |-> phase_feedback[0]; endproperty
   a_fb: assert property (p_fb) else $error("feedback does not follow phase node");
   property p_short; dout_short[1][*3] |-> ##[0:3] phase_feedback_oe_n[1]; endproperty
   a_short: assert property (p_short) else $error("shorted pad still driven");
   property p_fault; dout_short[1][*3] |-> ##[0:3] !fault_n; endproperty
   a_fault: assert property (p_fault) else $error("fault not shown");
   property p_cs; chip_select_n[*3] |-> sdo_oe_n; endproperty
   a_cs: assert property (p_cs) else $error("serial out driven while deselected");
   property p_shift; $fell(chip_select_n) |-> ##[1:4] shift_start ##1 !shift_start; endproperty
   a_shift: assert property (p_shift) else $error("no shift start pulse");
endmodule

bind gdic_top gdic_top_asserts #(.NPH(NPH)) u_gdic_top_asserts (
   .clk, .resetn, .high_side_cmd_n, .bridge_enable, .inhibit_sleep_n, .safe_off,
   .phase_node_above, .dout_short, .chip_select_n, .sdo_oe_n, .shift_start,
   .gate_hs_on, .gate_ls_on, .phase_feedback, .phase_feedback_oe_n, .fault_n,
   .supplies_en
);

// ===== test/gdic_mcu_model.sv
`timescale 1ns/1ps
module gdic_mcu_model
   import gdic_pkg::*;
#(
   parameter int NPH = NUM_PHASES,
   parameter int CLR_CYC = 4
)(
   // Clock
   input wire logic clk,
   // Requests from the bench
   input wire logic [NPH-1:0] want_hs,
   input wire logic [NPH-1:0] want_ls,
   input wire logic en_req,
   // Pins toward the driver
   output logic [NPH-1:0] high_side_cmd_n,
   output logic [NPH-1:0] low_side_cmd,
   output logic bridge_enable
);
   logic [7:0] hold_ff;
   initial begin
      high_side_cmd_n = '1;
      low_side_cmd = '0;
      bridge_enable = 1'b0;
      hold_ff = 8'h00;
   end
   always @(posedge clk) begin
      high_side_cmd_n <= ~want_hs;
      low_side_cmd <= want_ls;
   end
   // minimum clear time: a re-enable waits until the hold has run out
   always @(posedge clk) begin
      if (bridge_enable && !en_req) begin
         hold_ff <= 8'(CLR_CYC);
      end else if (hold_ff != 8'h00) begin
         hold_ff <= hold_ff - 8'h01;
      end
      bridge_enable <= en_req && (hold_ff == 8'h00);
   end
endmodule

// ===== test/test_gdic_top.sv
`timescale 1ns/1ps
module test_gdic_top;
   import gdic_pkg::*;
   localparam int NP = NUM_PHASES;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [NP-1:0] want_hs = '0;
   logic [NP-1:0] want_ls = '0;
   logic en_req = 1'b0;
   logic [NP-1:0] high_side_cmd_n, low_side_cmd;
   logic bridge_enable;
   logic inhibit_sleep_n = 1'b1;
   logic safe_off = 1'b0;
   logic [NP-1:0] phase_node_above = '0;
   logic vio_uv_det = 1'b0;
   logic vio_ov_det = 1'b0;
   logic bootstrap_supply_uv = 1'b0;
   logic io_supply_ok = 1'b1;
   logic [NUM_DOUT-1:0] dout_short = '0;
   logic chip_select_n = 1'b1;
   logic sdo_data = 1'b0;
   logic sdo_out, sdo_oe_n, shift_start, frame_end, fault_n, fault_oe_n;
   logic [NP-1:0] gate_hs_on, gate_ls_on, phase_feedback, phase_feedback_oe_n;
   logic supplies_en, sleep_mode, vio_thr_3v3, vio_mon_active, irq;
   int num_errors = 0;
   int checks_done = 0;

   gdic_top #(.NPH(NP)) u_gdic_top (
      .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .high_side_cmd_n, .low_side_cmd, .bridge_enable, .inhibit_sleep_n, .safe_off,
      .phase_node_above, .vio_uv_det, .vio_ov_det, .bootstrap_supply_uv, .io_supply_ok,
      .dout_short, .chip_select_n, .sdo_data, .sdo_out, .sdo_oe_n, .shift_start,
      .frame_end, .gate_hs_on, .gate_ls_on, .phase_feedback, .phase_feedback_oe_n,
      .fault_n, .fault_oe_n, .supplies_en, .sleep_mode, .vio_thr_3v3, .vio_mon_active,
      .irq
   );
   gdic_mcu_model #(.NPH(NP)) u_gdic_mcu_model (
      .clk, .want_hs, .want_ls, .en_req, .high_side_cmd_n, .low_side_cmd, .bridge_enable
   );

   // ----------------------------------------------------------------
   // Clock, tasks, watchdog
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, e, reg_rdata);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #20us;
      num_errors++;
      stop_test;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      tick(24);
      rd("ctrl", CTRL_OFS, 32'h610);
      rd("stat", STAT_OFS, 32'h400);
      rd("err", ERR_OFS, 32'h0);
      rd("mask", IRQ_MASK_OFS, 32'h0);
      rd("unmapped", 8'h20, 32'h0);
      @(posedge clk);
      en_req <= 1'b1;
      want_ls <= 3'b001;
      tick(10);
      chk("ls on", 32'h1, 32'({gate_hs_on, gate_ls_on}));
      tick(40);
      chk("ls full duty", 32'h1, 32'(gate_ls_on));
      @(posedge clk);
      want_ls <= 3'b000;
      want_hs <= 3'b001;
      tick(8);
      chk("hs dead", 32'h0, 32'(gate_hs_on));
      tick(20);
      chk("hs on", 32'h1, 32'(gate_hs_on));
      // Shorter dead time: the low side must now arrive before 16 cycles would allow
      wr(CTRL_OFS, 32'h60a);
      @(posedge clk);
      want_hs <= 3'b010;
      want_ls <= 3'b011;
      tick(8);
      chk("ls dead", 32'h0, 32'(gate_ls_on));
      tick(12);
      chk("ls after dead", 32'h1, 32'(gate_ls_on[0]));
      chk("both req", 32'h0, 32'({gate_hs_on[1], gate_ls_on[1]}));
      @(posedge clk);
      en_req <= 1'b0;
      tick(6);
      chk("ena off", 32'h0, 32'({gate_hs_on, gate_ls_on}));
      @(posedge clk);
      en_req <= 1'b1;
      tick(30);
      chk("ena again", 32'h1, 32'(gate_ls_on));
      @(posedge clk);
      safe_off <= 1'b1;
      tick(5);
      chk("safe_off", 32'h0, 32'({gate_hs_on, gate_ls_on}));
      rd("ctrl safe_off", CTRL_OFS, 32'h60a);
      @(posedge clk);
      safe_off <= 1'b0;
      dout_short <= 5'h0a;
      tick(6);
      chk("fault", 32'h0, 32'(fault_n));
      chk("pad off", 32'h2, 32'(phase_feedback_oe_n));
      chk("fault pad off", 32'h1, 32'(fault_oe_n));
      rd("latch set", STAT_OFS, 32'h1600);
      @(posedge clk);
      dout_short <= 5'h00;
      en_req <= 1'b0;
      tick(8);
      // Error bits outlive the latch, so the fault pin stays low until they are read
      chk("fault held", 32'h0, 32'(fault_n));
      rd("latch clr", STAT_OFS, 32'h400);
      @(posedge clk);
      en_req <= 1'b1;
      rd("err kept", ERR_OFS, 32'h50);
      rd("err read", ERR_OFS, 32'h0);
      rd("irq stat", IRQ_STAT_OFS, 32'h50);
      chk("irq masked", 32'h0, 32'(irq));
      wr(IRQ_MASK_OFS, 32'h10);
      tick(2);
      chk("irq on", 32'h1, 32'(irq));
      wr(IRQ_STAT_OFS, 32'h10);
      tick(2);
      chk("irq clr", 32'h0, 32'(irq));
      @(posedge clk);
      vio_uv_det <= 1'b1;
      vio_ov_det <= 1'b1;
      tick(4);
      @(posedge clk);
      vio_uv_det <= 1'b0;
      vio_ov_det <= 1'b0;
      tick(4);
      rd("err vio", ERR_OFS, 32'h3);
      wr(CTRL_OFS, 32'h50a);
      tick(2);
      chk("mon cfg", 32'h1, 32'({vio_mon_active, vio_thr_3v3}));
      @(posedge clk);
      vio_uv_det <= 1'b1;
      tick(4);
      @(posedge clk);
      vio_uv_det <= 1'b0;
      phase_node_above <= 3'b101;
      tick(5);
      rd("err mon off", ERR_OFS, 32'h0);
      chk("feedback", 32'h5, 32'(phase_feedback));
      @(posedge clk);
      chip_select_n <= 1'b0;
      sdo_data <= 1'b1;
      tick(5);
      chk("sdo on", 32'h1, 32'({sdo_oe_n, sdo_out}));
      @(posedge clk);
      chip_select_n <= 1'b1;
      tick(2);
      chk("frame end", 32'h1, 32'(frame_end));
      tick(2);
      chk("sdo hiz", 32'h2, 32'({sdo_oe_n, frame_end}));
      @(posedge clk);
      inhibit_sleep_n <= 1'b0;
      bootstrap_supply_uv <= 1'b1;
      tick(10);
      chk("sleep", 32'h2, 32'({sleep_mode, supplies_en}));
      chk("sleep gates", 32'h0, 32'({gate_hs_on, gate_ls_on}));
      @(posedge clk);
      inhibit_sleep_n <= 1'b1;
      bootstrap_supply_uv <= 1'b0;
      tick(20);
      rd("ctrl wiped", CTRL_OFS, 32'h610);
      wr(CTRL_OFS, 32'h60a);
      rd("ctrl again", CTRL_OFS, 32'h60a);
      stop_test;
   end
endmodule
